//--- hw/sdram_map.svh
// offsets, mode-register fields, reset values and timing counts
// assumes a 200 MHz mclk shared by both ends
`ifndef SDRAM_MAP_SVH
`define SDRAM_MAP_SVH
`define MCLK_PS 5000
`define TRP_NS 15
`define TRP_CYC ((`TRP_NS * 1000 + `MCLK_PS - 1) / `MCLK_PS)
`define TRC_NS 60
`define TRC_CYC ((`TRC_NS * 1000 + `MCLK_PS - 1) / `MCLK_PS)
`define REFI_NS 15625
`define REFI_CYC ((`REFI_NS * 1000) / `MCLK_PS)
`define MR_BL_HI 2
`define MR_BL_LO 0
`define MR_BT_BIT 3
`define MR_CL_HI 6
`define MR_CL_LO 4
`define MR_WB_BIT 9
`define MR_RESET 12'h020
`define AP_BIT 10
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_CMD 8'h0c
`define REG_STAT 8'h10
`define CTRL_RESET 2'h3
`endif

//--- hw/sdram_pkg.sv
// types shared by the memory end and the controller end
package sdram_pkg;
	typedef enum logic [2:0] {
		CMD_LMR = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR = 3'h4,
		CMD_RD = 3'h5,
		CMD_BST = 3'h6,
		CMD_NOP = 3'h7
	} cmd_t;
	typedef enum logic [1:0] {PM_RUN, PM_PDOWN, PM_SUSPEND, PM_SELF} pm_t;
	typedef enum logic [1:0] {CS_IDLE, CS_WAIT, CS_ACT, CS_REF} ctl_state_t;
endpackage

//--- hw/sdram_if.sv
// pins between controller and memory; resolves the shared data bus
// assumes both ends run on the same mclk
`timescale 1ns/1ps
interface sdram_if;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic bank_sel_lo;
	logic bank_sel_hi;
	logic [11:0] addr;
	logic low_byte_mask;
	logic high_byte_mask;
	logic [15:0] ctrl_dq;
	logic ctrl_dq_oe;
	logic [15:0] mem_dq;
	logic [1:0] mem_dq_oe;
	logic [15:0] data_bus;
	// ====================================================
	// bus resolution, per byte lane, undriven reads zero
	assign data_bus[7:0] = mem_dq_oe[0] ? mem_dq[7:0] :
		(ctrl_dq_oe ? ctrl_dq[7:0] : 8'h00);
	assign data_bus[15:8] = mem_dq_oe[1] ? mem_dq[15:8] :
		(ctrl_dq_oe ? ctrl_dq[15:8] : 8'h00);
	modport mem (
		input cke, cs_n, ras_n, cas_n, we_n, bank_sel_lo, bank_sel_hi,
		input addr, low_byte_mask, high_byte_mask, data_bus,
		output mem_dq, mem_dq_oe
	);
	modport ctrl (
		output cke, cs_n, ras_n, cas_n, we_n, bank_sel_lo, bank_sel_hi,
		output addr, low_byte_mask, high_byte_mask, ctrl_dq, ctrl_dq_oe,
		input data_bus, mem_dq_oe
	);
endinterface

//--- hw/sdram_device.sv
// four-bank synchronous dram memory end
// assumes controller pins come from logic on the same mclk
// Summary of operation
// - all pins sampled and launched on mclk rise
// - four banks, 4096 rows, 256 columns, 16 bits
// - activate opens addressed row in bank chosen by bank select
// - read/write start column from low eight address
// - burst lengths 1, 2, 4, 8, full page
// - burst order sequential or interleaved
// - read latency two or three clocks
// - auto close precharges bank after burst, except full-page bursts
// - banks precharge independently of each other
// - new column accepted every clock in burst
// - burst stop, or precharge of the burst bank or all banks, ends burst
// - optional single-location writes with burst reads
// - controller refreshes 4096 rows per 64 ms
// - auto refresh, power-down and self refresh
// - commands decoded only while chip select low
// - low clock enable freezes or powers down
// - precharge bit 10 selects all banks
// - load mode sets length, order, latency
`timescale 1ns/1ps
`include "sdram_map.svh"
module sdram_device #(
	parameter int ROW_BITS = 12,
	parameter int COL_BITS = 8,
	parameter int DATA_BITS = 16
)
(
	input wire logic mclk,
	input wire logic rst,
	sdram_if.mem pins,
	output logic refresh_busy,
	output logic powered_down,
	output logic self_refresh
);
	if (ROW_BITS != 12 || COL_BITS != 8 || DATA_BITS != 16)
	begin : g_bad
		$error("pins fix 12 row, 8 column and 16 data bits");
	end

	localparam int AW = 2 + ROW_BITS + COL_BITS;

	logic [DATA_BITS-1:0] mem [1 << AW];
	sdram_pkg::pm_t pm_reg;
	logic [11:0] mode_reg;
	logic [3:0] open_reg;
	logic [3:0] closing;
	logic [ROW_BITS-1:0] row_of [4];
	logic bst_on_reg;
	logic bst_wr_reg;
	logic bst_ap_reg;
	logic bst_full_reg;
	logic [1:0] bst_bank_reg;
	logic [7:0] bst_start_reg;
	logic [7:0] bst_idx_reg;
	logic [7:0] bst_mask_reg;
	logic [2:0] pv_reg;
	logic [15:0] pd_reg [3];
	logic [1:0] pmask_reg [3];
	logic [15:0] dq_reg;
	logic [1:0] oe_reg;
	logic [5:0] ref_cnt_reg;
	logic [11:0] ref_row_reg;

	// ====================================================
	// command decode
	wire sdram_pkg::cmd_t cmd =
		sdram_pkg::cmd_t'({pins.ras_n, pins.cas_n, pins.we_n});
	wire valid = pins.cke;
	wire ref_busy = ref_cnt_reg != 6'h00;
	wire sel = valid & ~pins.cs_n & ~ref_busy;
	wire [1:0] bank = {pins.bank_sel_hi, pins.bank_sel_lo};
	wire idle_all = ~|open_reg & ~|closing & ~bst_on_reg & ~ref_busy;
	wire bank_ready = ~open_reg[bank] & ~closing[bank];
	wire do_act = sel & (cmd == sdram_pkg::CMD_ACT) & bank_ready;
	wire do_pre = sel & (cmd == sdram_pkg::CMD_PRE);
	wire do_ref = sel & (cmd == sdram_pkg::CMD_REF) & idle_all;
	wire do_lmr = sel & (cmd == sdram_pkg::CMD_LMR) & idle_all;
	wire self_go = ~pins.cke & ~pins.cs_n & (cmd == sdram_pkg::CMD_REF)
		& idle_all & (pm_reg == sdram_pkg::PM_RUN);
	wire new_wr = cmd == sdram_pkg::CMD_WR;
	wire new_rw = sel & open_reg[bank] &
		(new_wr | (cmd == sdram_pkg::CMD_RD));
	wire pre_hit = pins.addr[`AP_BIT] | (bank == bst_bank_reg);
	wire stop = bst_on_reg & sel & ((cmd == sdram_pkg::CMD_BST) |
		((cmd == sdram_pkg::CMD_PRE) & pre_hit));

	// ====================================================
	// burst addressing
	wire [2:0] bl_code = mode_reg[`MR_BL_HI:`MR_BL_LO];
	wire full_page = bl_code[2];
	wire [7:0] bl_mask = full_page ? 8'hff :
		8'((8'h01 << bl_code) - 8'h01);
	wire single_wr = mode_reg[`MR_WB_BIT] & new_wr;
	wire [7:0] new_mask = single_wr ? 8'h00 : bl_mask;
	wire new_full = full_page & ~single_wr;
	wire cont = bst_on_reg & valid & ~stop & ~new_rw;
	wire beat = new_rw | cont;
	wire [7:0] cur_start = new_rw ? pins.addr[7:0] : bst_start_reg;
	wire [7:0] cur_idx = new_rw ? 8'h00 : bst_idx_reg;
	wire [7:0] cur_mask = new_rw ? new_mask : bst_mask_reg;
	wire cur_full = new_rw ? new_full : bst_full_reg;
	wire cur_wr = new_rw ? new_wr : bst_wr_reg;
	wire cur_ap = new_rw ? pins.addr[`AP_BIT] : bst_ap_reg;
	wire [1:0] cur_bank = new_rw ? bank : bst_bank_reg;
	wire [7:0] seq_col = 8'(cur_start + cur_idx);
	wire [7:0] low_col = (mode_reg[`MR_BT_BIT] & ~cur_full) ?
		(cur_start ^ cur_idx) : seq_col;
	wire [7:0] col = (cur_start & ~cur_mask) | (low_col & cur_mask);
	wire last = ~cur_full & ((cur_idx & cur_mask) == cur_mask);
	wire [AW-1:0] idx = {cur_bank, row_of[cur_bank], col};
	wire [1:0] lane_mask = {pins.high_byte_mask, pins.low_byte_mask};
	wire [15:0] rd_word = mem[idx];
	wire cl3 = mode_reg[`MR_CL_HI:`MR_CL_LO] == 3'h3;
	wire out_v = cl3 ? pv_reg[2] : pv_reg[1];
	wire [15:0] out_d = cl3 ? pd_reg[2] : pd_reg[1];
	wire [1:0] out_m = cl3 ? pmask_reg[2] : pmask_reg[1];
	wire sdram_pkg::pm_t pm_next = pins.cke ? sdram_pkg::PM_RUN :
		(pm_reg != sdram_pkg::PM_RUN) ? pm_reg :
		self_go ? sdram_pkg::PM_SELF :
		(bst_on_reg | (|pv_reg)) ? sdram_pkg::PM_SUSPEND :
		sdram_pkg::PM_PDOWN;

	// ====================================================
	// per-bank row state and self-timed close
	for (genvar b = 0; b < 4; b++)
	begin : g_bank
		logic open_q;
		logic [ROW_BITS-1:0] row_q;
		logic [3:0] cnt_q;
		wire here = bank == 2'(b);
		wire hit_pre = do_pre & (pins.addr[`AP_BIT] | here);
		wire hit_ap = beat & last & cur_ap & (cur_bank == 2'(b));
		always_ff @(posedge mclk)
		begin
			if (rst)
			begin
				open_q <= 1'b0;
				row_q <= '0;
				cnt_q <= 4'h0;
			end
			else if ((hit_pre | hit_ap) & open_q)
			begin
				open_q <= 1'b0;
				cnt_q <= 4'(`TRP_CYC);
			end
			else if (do_act & here)
			begin
				open_q <= 1'b1;
				row_q <= pins.addr[ROW_BITS-1:0];
			end
			else if (cnt_q != 4'h0)
				cnt_q <= cnt_q - 4'h1;
		end
		assign open_reg[b] = open_q;
		assign row_of[b] = row_q;
		assign closing[b] = cnt_q != 4'h0;
	end

	// ====================================================
	// mode register and burst tracker
	always_ff @(posedge mclk)
	begin
		if (rst)
			mode_reg <= `MR_RESET;
		else if (do_lmr)
			mode_reg <= pins.addr;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			bst_on_reg <= 1'b0;
		else if (stop)
			bst_on_reg <= 1'b0;
		else if (beat)
			bst_on_reg <= ~last;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			bst_idx_reg <= 8'h00;
			bst_start_reg <= 8'h00;
			bst_mask_reg <= 8'h00;
			bst_full_reg <= 1'b0;
			bst_wr_reg <= 1'b0;
			bst_ap_reg <= 1'b0;
			bst_bank_reg <= 2'h0;
		end
		else if (beat)
		begin
			bst_idx_reg <= 8'(cur_idx + 8'h01);
			bst_start_reg <= cur_start;
			bst_mask_reg <= cur_mask;
			bst_full_reg <= cur_full;
			bst_wr_reg <= cur_wr;
			bst_ap_reg <= cur_ap;
			bst_bank_reg <= cur_bank;
		end
	end

	// ====================================================
	// array write with byte lanes
	always_ff @(posedge mclk)
	begin
		if (beat & cur_wr & ~lane_mask[0])
			mem[idx][7:0] <= pins.data_bus[7:0];
		if (beat & cur_wr & ~lane_mask[1])
			mem[idx][15:8] <= pins.data_bus[15:8];
	end

	// ====================================================
	// read pipeline, held while the clock is suspended
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pv_reg <= 3'h0;
			dq_reg <= 16'h0000;
			oe_reg <= 2'h0;
			for (int i = 0; i < 3; i++)
			begin
				pd_reg[i] <= 16'h0000;
				pmask_reg[i] <= 2'h0;
			end
		end
		else if (valid)
		begin
			pv_reg <= {pv_reg[1:0], beat & ~cur_wr};
			pd_reg[0] <= rd_word;
			pd_reg[1] <= pd_reg[0];
			pd_reg[2] <= pd_reg[1];
			pmask_reg[0] <= lane_mask;
			pmask_reg[1] <= pmask_reg[0];
			pmask_reg[2] <= pmask_reg[1];
			dq_reg <= out_d;
			oe_reg <= {2{out_v}} & ~out_m;
		end
	end

	assign pins.mem_dq = dq_reg;
	assign pins.mem_dq_oe = oe_reg;

	// ====================================================
	// refresh and power state
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ref_cnt_reg <= 6'h00;
			ref_row_reg <= 12'h000;
			refresh_busy <= 1'b0;
		end
		else if (do_ref | self_go)
		begin
			ref_cnt_reg <= 6'(`TRC_CYC);
			ref_row_reg <= ref_row_reg + 12'h001;
			refresh_busy <= 1'b1;
		end
		else if (ref_busy)
		begin
			ref_cnt_reg <= ref_cnt_reg - 6'h01;
			refresh_busy <= ref_cnt_reg > 6'h01;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pm_reg <= sdram_pkg::PM_RUN;
			powered_down <= 1'b0;
			self_refresh <= 1'b0;
		end
		else
		begin
			pm_reg <= pm_next;
			powered_down <= pm_next != sdram_pkg::PM_RUN;
			self_refresh <= pm_next == sdram_pkg::PM_SELF;
		end
	end
endmodule

//--- hw/sdram_controller.sv
// controller end: register port to software, command pins to memory
// assumes the memory end shares mclk; software strobes are one cycle
`timescale 1ns/1ps
`include "sdram_map.svh"
module sdram_controller
(
	input wire logic mclk,
	input wire logic rst,
	sdram_if.ctrl pins,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	logic [1:0] ctrl_reg;
	logic [13:0] addr_reg;
	logic [17:0] wd_reg;
	logic pend_reg;
	sdram_pkg::cmd_t pend_cmd_reg;
	sdram_pkg::ctl_state_t st_reg;
	sdram_pkg::ctl_state_t after_reg;
	logic [3:0] wait_reg;
	logic [11:0] refc_reg;
	logic ref_due_reg;
	logic [3:0] open_reg;
	logic [11:0] row_reg [4];
	logic cs_n_reg;
	sdram_pkg::cmd_t cmd_reg;
	logic [1:0] ba_reg;
	logic [11:0] a_reg;
	logic dqoe_reg;
	logic [15:0] rd_word_reg;
	logic [7:0] rd_cnt_reg;

	// ====================================================
	// decode
	wire [1:0] sw_bank = addr_reg[13:12];
	wire wr_cmd = reg_wr & (reg_addr == `REG_CMD);
	wire ref_go = ref_due_reg & ctrl_reg[1] & ctrl_reg[0];
	wire need_pre = (pend_cmd_reg == sdram_pkg::CMD_ACT) &
		open_reg[sw_bank] & (row_reg[sw_bank] != addr_reg[11:0]);
	wire in_idle = st_reg == sdram_pkg::CS_IDLE;
	wire pend_done = (in_idle & pend_reg & ~ref_go & ~need_pre) |
		(st_reg == sdram_pkg::CS_ACT);
	wire [31:0] rd_mux =
		(reg_addr == `REG_CTRL) ? {30'h0, ctrl_reg} :
		(reg_addr == `REG_ADDR) ? {18'h0, addr_reg} :
		(reg_addr == `REG_DATA) ? {8'h0, rd_cnt_reg, rd_word_reg} :
		(reg_addr == `REG_STAT) ? {24'h0, open_reg, 1'b0, ref_due_reg,
			~in_idle, pend_reg} : 32'h0;

	// ====================================================
	// software registers
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ctrl_reg <= `CTRL_RESET;
			addr_reg <= 14'h0000;
			wd_reg <= 18'h00000;
			pend_cmd_reg <= sdram_pkg::CMD_NOP;
			reg_rdata <= 32'h0;
		end
		else
		begin
			if (reg_wr & (reg_addr == `REG_CTRL))
				ctrl_reg <= reg_wdata[1:0];
			if (reg_wr & (reg_addr == `REG_ADDR))
				addr_reg <= reg_wdata[13:0];
			if (reg_wr & (reg_addr == `REG_DATA))
				wd_reg <= reg_wdata[17:0];
			if (wr_cmd & ~pend_reg)
				pend_cmd_reg <= sdram_pkg::cmd_t'(reg_wdata[2:0]);
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			pend_reg <= 1'b0;
		else if (wr_cmd & ~pend_reg)
			pend_reg <= 1'b1;
		else if (pend_done)
			pend_reg <= 1'b0;
	end

	// ====================================================
	// refresh interval timer, due flag set wins over clear
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			refc_reg <= 12'(`REFI_CYC - 1);
			ref_due_reg <= 1'b0;
		end
		else
		begin
			refc_reg <= (refc_reg == 12'h000) ? 12'(`REFI_CYC - 1) :
				refc_reg - 12'h001;
			ref_due_reg <= (refc_reg == 12'h000) |
				(ref_due_reg & (st_reg != sdram_pkg::CS_REF));
		end
	end

	// ====================================================
	// command sequencer
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			st_reg <= sdram_pkg::CS_IDLE;
			after_reg <= sdram_pkg::CS_IDLE;
			wait_reg <= 4'h0;
			cs_n_reg <= 1'b1;
			cmd_reg <= sdram_pkg::CMD_NOP;
			ba_reg <= 2'h0;
			a_reg <= 12'h000;
			dqoe_reg <= 1'b0;
		end
		else
		begin
			cs_n_reg <= 1'b1;
			cmd_reg <= sdram_pkg::CMD_NOP;
			dqoe_reg <= 1'b0;
			unique case (st_reg)
				sdram_pkg::CS_IDLE:
				begin
					if (ref_go)
					begin
						cs_n_reg <= 1'b0;
						cmd_reg <= sdram_pkg::CMD_PRE;
						a_reg <= 12'(1 << `AP_BIT);
						wait_reg <= 4'(`TRP_CYC);
						after_reg <= sdram_pkg::CS_REF;
						st_reg <= sdram_pkg::CS_WAIT;
					end
					else if (pend_reg & need_pre)
					begin
						cs_n_reg <= 1'b0;
						cmd_reg <= sdram_pkg::CMD_PRE;
						ba_reg <= sw_bank;
						a_reg <= 12'h000;
						wait_reg <= 4'(`TRP_CYC);
						after_reg <= sdram_pkg::CS_ACT;
						st_reg <= sdram_pkg::CS_WAIT;
					end
					else if (pend_reg)
					begin
						cs_n_reg <= 1'b0;
						cmd_reg <= pend_cmd_reg;
						ba_reg <= sw_bank;
						a_reg <= addr_reg[11:0];
						dqoe_reg <= pend_cmd_reg == sdram_pkg::CMD_WR;
					end
				end
				sdram_pkg::CS_WAIT:
				begin
					wait_reg <= wait_reg - 4'h1;
					if (wait_reg == 4'h1)
						st_reg <= after_reg;
				end
				sdram_pkg::CS_ACT:
				begin
					cs_n_reg <= 1'b0;
					cmd_reg <= sdram_pkg::CMD_ACT;
					ba_reg <= sw_bank;
					a_reg <= addr_reg[11:0];
					st_reg <= sdram_pkg::CS_IDLE;
				end
				sdram_pkg::CS_REF:
				begin
					cs_n_reg <= 1'b0;
					cmd_reg <= sdram_pkg::CMD_REF;
					wait_reg <= 4'(`TRC_CYC);
					after_reg <= sdram_pkg::CS_IDLE;
					st_reg <= sdram_pkg::CS_WAIT;
				end
			endcase
		end
	end

	// ====================================================
	// open-row table follows the issued commands
	always_ff @(posedge mclk)
	begin
		if (rst)
			open_reg <= 4'h0;
		else if (~cs_n_reg & (cmd_reg == sdram_pkg::CMD_ACT))
			open_reg[ba_reg] <= 1'b1;
		else if (~cs_n_reg & (cmd_reg == sdram_pkg::CMD_PRE))
			open_reg <= a_reg[`AP_BIT] ? 4'h0 :
				open_reg & ~(4'h1 << ba_reg);
		else if (~cs_n_reg & a_reg[`AP_BIT] &
			((cmd_reg == sdram_pkg::CMD_RD) | (cmd_reg == sdram_pkg::CMD_WR)))
			open_reg[ba_reg] <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (~cs_n_reg & (cmd_reg == sdram_pkg::CMD_ACT))
			row_reg[ba_reg] <= a_reg;
	end

	// ====================================================
	// capture of read data whenever the memory drives the bus
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rd_word_reg <= 16'h0000;
			rd_cnt_reg <= 8'h00;
		end
		else if (|pins.mem_dq_oe)
		begin
			rd_word_reg <= pins.data_bus;
			rd_cnt_reg <= rd_cnt_reg + 8'h01;
		end
	end

	assign pins.cke = ctrl_reg[0];
	assign pins.cs_n = cs_n_reg;
	assign {pins.ras_n, pins.cas_n, pins.we_n} = cmd_reg;
	assign {pins.bank_sel_hi, pins.bank_sel_lo} = ba_reg;
	assign pins.addr = a_reg;
	assign {pins.high_byte_mask, pins.low_byte_mask} = wd_reg[17:16];
	assign pins.ctrl_dq = wd_reg[15:0];
	assign pins.ctrl_dq_oe = dqoe_reg;
endmodule

//--- sim/sdram_link_chk.sv
// link checker: watches the pins between controller and memory
// assumes one mclk and a synchronous active-high rst
`timescale 1ns/1ps
`include "sdram_map.svh"
module sdram_link_chk
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic bank_sel_lo,
	input wire logic bank_sel_hi,
	input wire logic [11:0] addr,
	input wire logic low_byte_mask,
	input wire logic high_byte_mask,
	input wire logic ctrl_dq_oe,
	input wire logic [15:0] mem_dq,
	input wire logic [1:0] mem_dq_oe
);
	localparam int REF_LIMIT = `REFI_CYC + 80;
	logic [11:0] mode_reg;
	logic [3:0] open_reg;
	logic seen_reg;
	logic [12:0] gap_reg;
	wire [2:0] code = {ras_n, cas_n, we_n};
	wire live = cke && !cs_n;
	wire rd_cmd = live && code == sdram_pkg::CMD_RD;
	wire wr_cmd = live && code == sdram_pkg::CMD_WR;
	wire act_cmd = live && code == sdram_pkg::CMD_ACT;
	wire pre_cmd = live && code == sdram_pkg::CMD_PRE;
	wire ref_cmd = live && code == sdram_pkg::CMD_REF;
	wire lmr_cmd = live && code == sdram_pkg::CMD_LMR;
	wire [1:0] mask_pair = {high_byte_mask, low_byte_mask};
	wire [3:0] bank_bit = 4'h1 << {bank_sel_hi, bank_sel_lo};
	wire cl3 = mode_reg[6:4] == 3'h3;
	wire [3:0] shut = pre_cmd && addr[10] ? 4'hf :
		(pre_cmd || ((rd_cmd || wr_cmd) && addr[10])) ? bank_bit : 4'h0;
	wire [3:0] open_next = (open_reg & ~shut) | (act_cmd ? bank_bit : 4'h0);
	// ==========================================================
	// pin-level view of mode, open banks and refresh spacing
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			mode_reg <= `MR_RESET;
			open_reg <= 4'h0;
			seen_reg <= 1'b0;
			gap_reg <= 13'h0;
		end
		else
		begin
			mode_reg <= lmr_cmd ? addr : mode_reg;
			open_reg <= open_next;
			seen_reg <= seen_reg || rd_cmd;
			gap_reg <= ref_cmd ? 13'h0 : gap_reg + 13'(cke);
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	a_read_two:
	assert property (rd_cmd && !cl3 |-> ##3 mem_dq_oe == ~$past(mask_pair, 3))
		else $error("read word late or mis-masked at latency two");
	a_read_three:
	assert property (rd_cmd && cl3 |-> ##4 mem_dq_oe == ~$past(mask_pair, 4))
		else $error("read word late or mis-masked at latency three");
	a_burst_four:
	assert property (rd_cmd && !cl3 && mode_reg[2:0] == 3'h2 && mask_pair == 2'h0
		|-> ##3 (mem_dq_oe == 2'h3)[*4])
		else $error("four-word burst not driven four cycles");
	a_bus_quiet:
	assert property (!seen_reg |-> mem_dq_oe == 2'h0)
		else $error("memory drove data with no read issued");
	a_wr_only:
	assert property (ctrl_dq_oe |-> wr_cmd)
		else $error("controller drove data outside a write");
	a_act_closed:
	assert property (act_cmd |-> (open_reg & bank_bit) == 4'h0)
		else $error("activate to a bank with a row open");
	a_mode_idle:
	assert property (lmr_cmd |-> open_reg == 4'h0)
		else $error("load mode with a bank open");
	a_ref_idle:
	assert property (ref_cmd |-> open_reg == 4'h0)
		else $error("refresh with a bank open");
	a_ref_spacing:
	assert property (gap_reg < REF_LIMIT)
		else $error("refresh interval exceeded");
	a_cke_freeze:
	assert property (!cke |=> $stable(mem_dq_oe) && $stable(mem_dq))
		else $error("memory outputs moved while clock disabled");
	a_reset_idle:
	assert property ($fell(rst) |-> cs_n && cke && mem_dq_oe == 2'h0 && !ctrl_dq_oe)
		else $error("pins not idle after reset");
endmodule

//--- sim/tb_quad_bank_sdram_core.sv
// bench: controller and memory joined by one interface, software port
// assumes hw/ files compiled first and a 200 MHz mclk
`timescale 1ns/1ps
`include "sdram_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	n_mismatch++; $display("wrong value at %0t: got %h expected %h", \
	$time, g, e); end end
module tb_quad_bank_sdram_core;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic refresh_busy;
	logic powered_down;
	logic self_refresh;
	int n_mismatch = 0;
	int samples_checked = 0;
	int seed = 58;
	int bl = 1;
	int il = 0;
	int sw = 0;
	int row_of [4];
	logic [3:0] open_m = 4'h0;
	logic [15:0] mem [int];
	logic [31:0] d;
	logic [11:0] modes [6] = '{12'h022, 12'h02a, 12'h03b, 12'h031,
		12'h023, 12'h039};
	sdram_if bus ();
	sdram_device u_sdram_device (.mclk(mclk), .rst(rst), .pins(bus),
		.refresh_busy(refresh_busy), .powered_down(powered_down),
		.self_refresh(self_refresh));
	sdram_controller u_sdram_controller (.mclk(mclk), .rst(rst),
		.pins(bus), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	sdram_link_chk u_sdram_link_chk (.mclk(mclk), .rst(rst), .cke(bus.cke),
		.cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n),
		.we_n(bus.we_n), .bank_sel_lo(bus.bank_sel_lo),
		.bank_sel_hi(bus.bank_sel_hi), .addr(bus.addr),
		.low_byte_mask(bus.low_byte_mask),
		.high_byte_mask(bus.high_byte_mask), .ctrl_dq_oe(bus.ctrl_dq_oe),
		.mem_dq(bus.mem_dq), .mem_dq_oe(bus.mem_dq_oe));
	initial
	begin
		forever #2.5 mclk = ~mclk;
	end
	// ==========================================================
	// reference model helpers
	function automatic int rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int col_at(int s, int k);
		int off;
		off = il ? (s ^ k) : (s + k);
		return (s & ~(bl - 1)) | (off & (bl - 1));
	endfunction
	function automatic int key(int b, int c);
		return (b << 20) | (row_of[b] << 8) | c;
	endfunction
	// ==========================================================
	// software port and command tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic cmd(input sdram_pkg::cmd_t c, input int b, input int a);
		wr(`REG_ADDR, 32'((b << 12) | a));
		wr(`REG_CMD, 32'(c));
		d = 32'h3;
		for (int i = 0; i < 100 && d[1:0] !== 2'b00; i++)
			rd(`REG_STAT);
		`CHK(d[1:0], 2'b00)
	endtask
	task automatic act(input int b, input int r);
		cmd(sdram_pkg::CMD_ACT, b, r);
		row_of[b] = r;
		open_m[b] = 1'b1;
	endtask
	task automatic chk_open();
		rd(`REG_STAT);
		`CHK(d[7:4], open_m)
	endtask
	task automatic wrt(input int b, input int c, input logic [15:0] v,
		input logic [1:0] m);
		int ky;
		logic [15:0] x;
		wr(`REG_DATA, {14'h0, m, v});
		cmd(sdram_pkg::CMD_WR, b, c);
		for (int k = 0; k < (sw ? 1 : bl); k++)
		begin
			ky = key(b, col_at(c, k));
			x = mem.exists(ky) ? mem[ky] : 16'hxxxx;
			if (!m[0]) x[7:0] = k ? 8'h00 : v[7:0];
			if (!m[1]) x[15:8] = k ? 8'h00 : v[15:8];
			mem[ky] = x;
		end
	endtask
	task automatic rdk(input int b, input int c, input bit ap);
		logic [7:0] n0;
		wr(`REG_DATA, 32'h0);
		rd(`REG_DATA);
		n0 = d[23:16];
		cmd(sdram_pkg::CMD_RD, b, c | (int'(ap) << 10));
		repeat (12) @(posedge mclk);
		rd(`REG_DATA);
		`CHK(d[15:0], mem[key(b, col_at(c, bl - 1))])
		`CHK(d[23:16], 8'(n0 + bl))
		if (ap) open_m[b] = 1'b0;
	endtask
	task automatic lmr(input logic [11:0] op);
		cmd(sdram_pkg::CMD_PRE, 0, 12'h400);
		open_m = 4'h0;
		chk_open();
		cmd(sdram_pkg::CMD_LMR, 0, op);
		bl = 1 << op[2:0];
		il = op[3];
		sw = op[9];
		for (int b = 0; b < 4; b++)
			act(b, row_of[b]);
	endtask
	task automatic summarize();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		summarize();
	end
	// ==========================================================
	// main sequence
	initial
	begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		rd(`REG_CTRL);
		`CHK(d[1:0], 2'(`CTRL_RESET))
		wr(8'h14, 32'hffffffff);
		rd(8'h14);
		`CHK(d, 32'h0)
		chk_open();
		for (int b = 0; b < 4; b++)
		begin
			act(b, rnd() & 32'hfff);
			for (int c = 0; c < 8; c++)
				wrt(b, c, 16'(rnd()), 2'b00);
		end
		chk_open();
		wrt(1, 2, 16'(rnd()), 2'b01);
		wrt(2, 3, 16'(rnd()), 2'b10);
		for (int b = 0; b < 4; b++)
		begin
			rdk(b, 2, 0);
			rdk(b, 3, 0);
		end
		foreach (modes[i])
		begin
			lmr(modes[i]);
			rdk(i & 3, 5, 0);
			rdk(i & 3, rnd() & 7, 0);
		end
		lmr(12'h021);
		wrt(1, 2, 16'(rnd()), 2'b00);
		rdk(1, 3, 0);
		rdk(1, 2, 0);
		lmr(12'h222);
		wrt(2, 0, 16'(rnd()), 2'b00);
		rdk(2, 0, 0);
		rdk(2, 1, 0);
		lmr(12'h020);
		rdk(0, 4, 1);
		chk_open();
		rdk(1, 4, 0);
		act(1, row_of[1] ^ 1);
		wrt(1, 6, 16'(rnd()), 2'b00);
		rdk(1, 6, 0);
		cmd(sdram_pkg::CMD_PRE, 1, 0);
		open_m[1] = 1'b0;
		chk_open();
		wr(`REG_ADDR, 32'(row_of[0]));
		@(posedge mclk);
		reg_addr <= `REG_CMD;
		reg_wdata <= 32'(sdram_pkg::CMD_ACT);
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wdata <= 32'(sdram_pkg::CMD_PRE);
		@(posedge mclk);
		reg_wr <= 1'b0;
		open_m[0] = 1'b1;
		repeat (20) @(posedge mclk);
		chk_open();
		wr(`REG_DATA, 32'h10000);
		cmd(sdram_pkg::CMD_RD, 3, 5);
		repeat (12) @(posedge mclk);
		rd(`REG_DATA);
		`CHK(d[15:0], mem[key(3, 5)] & 16'hff00)
		wr(`REG_CTRL, 32'h2);
		repeat (20) @(posedge mclk);
		`CHK(powered_down, 1'b1)
		`CHK(self_refresh, 1'b0)
		wr(`REG_CTRL, 32'h3);
		repeat (4) @(posedge mclk);
		`CHK(powered_down, 1'b0)
		rdk(3, 5, 0);
		repeat (3400) @(posedge mclk);
		open_m = 4'h0;
		chk_open();
		cmd(sdram_pkg::CMD_REF, 0, 0);
		`CHK(refresh_busy, 1'b1)
		repeat (14) @(posedge mclk);
		`CHK(refresh_busy, 1'b0)
		act(3, row_of[3]);
		rdk(3, 6, 0);
		summarize();
	end
endmodule
